// >>> core/lock_detect_pkg.sv
// Constants, field layouts and types shared by the lock detector design.
//
// Summary of operation
// - Lock is declared only after a chosen number of back-to-back in-window counts, code 0..7 giving 5, 32, 96, 256, 512, 2048, 8192 or 65535.
// - Bit 3 of the configuration resets to one and turns lock detection on while set.
// - Bit 6 picks the window: one uses the digital timer, zero a fixed one-shot window, 10 ns rounded up to one 20 ns system cycle.
// - Bits 9:7 set the digital window to a half, one, 2, 4, 8, 16, 32 or 64 timer cycles.
// - Bits 11:10 set the timer rate, 00 fastest and 11 slowest, resetting to zero.
// - With bit 13 set, a loss of lock for any reason triggers exactly one automatic relock attempt.
// - The configuration register resets to 0x00014D.
package lock_detect_pkg;

  // ==========================================================================
  // Register map. Printed offsets are word indices; byte address is index * 4.
  localparam logic [7:0]  CFG_INDEX      = 8'h07;
  localparam logic [7:0]  STATUS_INDEX   = 8'h08;
  localparam logic [7:0]  MASK_INDEX     = 8'h09;
  localparam logic [7:0]  STATE_INDEX    = 8'h0A;
  localparam int          REG_WIDTH      = 24;
  localparam logic [23:0] CFG_RESET      = 24'h00014D;
  localparam logic [2:0]  MASK_RESET     = 3'h0;

  // ==========================================================================
  // Configuration field positions.
  localparam int CFG_COUNT_LSB  = 0;
  localparam int CFG_ENABLE_BIT = 3;
  localparam int CFG_WTYPE_BIT  = 6;
  localparam int CFG_DUR_LSB    = 7;
  localparam int CFG_RATE_LSB   = 10;
  localparam int CFG_RELOCK_BIT = 13;

  // Status bit positions.
  localparam int ST_GAINED_BIT = 0;
  localparam int ST_LOST_BIT   = 1;
  localparam int ST_RELOCK_BIT = 2;
  localparam int STATUS_WIDTH  = 3;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_PS     = 20000;
  localparam int ANALOG_WINDOW_PS  = 10000;
  localparam int ANALOG_WIN_CYCLES = (ANALOG_WINDOW_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                     (ANALOG_WINDOW_PS / CLK_PERIOD_PS);
  localparam int WIN_CNT_WIDTH     = 10;
  localparam int TALLY_WIDTH       = 17;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic [9:0] rsvd_hi;
    logic       relock;
    logic       rsvd12;
    logic [1:0] rate;
    logic [2:0] duration;
    logic       wtype;
    logic [1:0] rsvd5_4;
    logic       enable;
    logic [2:0] count_code;
  } lock_cfg_type;

  typedef struct packed {
    logic relock;
    logic lost;
    logic gained;
  } lock_events_type;

  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00,
    CMP_OPEN = 2'b01,
    CMP_HIT  = 2'b11
  } cmp_state_type;

endpackage : lock_detect_pkg

// >>> core/edge_sync.sv
// Three-stage pin synchroniser reporting a rising edge once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      rise_out
);
  logic [2:0] stage_q;
  logic       level_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], pin_in};
    end
  end

  // The level only moves when the two settled stages agree.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

  assign rise_out = (stage_q[1] == stage_q[2]) && stage_q[2] && !level_q;
endmodule // edge_sync
`default_nettype wire

// >>> core/window_timer.sv
// Countdown timer that holds a comparison window open for a loaded number of cycles.
`timescale 1ns/1ps
`default_nettype none
module window_timer #(
  parameter int WIDTH = 10
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] cycles_in,
  output logic                  open_out,
  output logic                  expire_out
);
  logic [WIDTH-1:0] remain_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      remain_q <= '0;
    end else if (start_in) begin
      remain_q <= cycles_in;
    end else if (remain_q != '0) begin
      remain_q <= remain_q - 1'b1;
    end
  end

  assign open_out   = (remain_q != '0);
  assign expire_out = (remain_q == {{(WIDTH-1){1'b0}}, 1'b1}) && !start_in;
endmodule // window_timer
`default_nettype wire

// >>> core/lock_detector.sv
// Lock detector with programmable window, lock count, single relock try and Avalon-MM registers.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module lock_detector (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Comparison inputs from the reference and divided oscillator paths.
  input  wire logic        ref_edge_in,
  input  wire logic        div_edge_in,
  // Results.
  output logic             lock_flag_out,
  output logic             relock_req_out,
  output logic             irq_out
);
  import lock_detect_pkg::*;

  // ==========================================================================
  // Helper functions.

  // Number of in-window counts needed to declare lock.
  function automatic logic [TALLY_WIDTH-1:0] lock_target(input logic [2:0] code);
    logic [TALLY_WIDTH-1:0] t;
    t = '0;
    unique case (code)
      3'h0: t = 17'd5;
      3'h1: t = 17'd32;
      3'h2: t = 17'd96;
      3'h3: t = 17'd256;
      3'h4: t = 17'd512;
      3'h5: t = 17'd2048;
      3'h6: t = 17'd8192;
      3'h7: t = 17'd65535;
    endcase
    return t;
  endfunction

  // Window length in system cycles. Duration code 0 gives half a timer tick, code d gives 2^(d-1) ticks;
  // a timer tick lasts 2^rate system cycles. Never shorter than one cycle.
  function automatic logic [WIN_CNT_WIDTH-1:0] window_cycles(input lock_cfg_type c);
    logic [3:0]               shift;
    logic [WIN_CNT_WIDTH-1:0] len;
    shift  = 4'(c.duration) + 4'(c.rate);
    len    = '0;
    if (c.wtype) begin
      len    = (c.duration == 3'h0) ? ((10'h001 << c.rate) >> 1)
                                    : (10'h001 << (shift - 4'h1));
    end else begin
      len    = WIN_CNT_WIDTH'(ANALOG_WIN_CYCLES);
    end
    if (len == '0) begin
      len = 10'h001;
    end
    return len;
  endfunction

  // Map a byte address onto a word index.
  function automatic logic [7:0] word_index(input logic [7:0] addr);
    return {2'h0, addr[7:2]};
  endfunction

  // ==========================================================================
  // Configuration and register state.
  lock_cfg_type            cfg_q;
  logic [STATUS_WIDTH-1:0] status_q;
  logic [STATUS_WIDTH-1:0] mask_q;
  logic [31:0]             readdata_q;
  logic                    ack_q;
  logic                    bus_req;
  logic                    wr_take;
  logic                    rd_take;
  logic [7:0]              idx;
  logic                    status_rd;
  logic [23:0]             cfg_bits;
  logic [23:0]             cfg_merge;

  // ==========================================================================
  // Comparison and lock state.
  logic                    ref_rise;
  logic                    div_rise;
  logic                    win_open;
  logic                    win_expire;
  logic                    win_start;
  cmp_state_type           cmp_q;
  cmp_state_type           cmp_d;
  logic                    hit;
  logic                    miss;
  logic [TALLY_WIDTH-1:0]  tally_q;
  logic [TALLY_WIDTH-1:0]  target;
  logic                    lock_q;
  logic                    lock_prev_q;
  logic                    relock_armed_q;
  logic                    relock_req_q;
  logic                    lock_gained;
  logic                    lock_lost;
  lock_events_type         events;

  // ==========================================================================
  // Input synchronisers.
  edge_sync u_ref_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (ref_edge_in),
    .rise_out   (ref_rise)
  );

  edge_sync u_div_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (div_edge_in),
    .rise_out   (div_rise)
  );

  // ==========================================================================
  // Window timer, started by each reference edge.
  assign win_start = ref_rise && cfg_q.enable;

  window_timer #(
    .WIDTH (WIN_CNT_WIDTH)
  ) u_window (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (win_start),
    .cycles_in  (window_cycles(cfg_q)),
    .open_out   (win_open),
    .expire_out (win_expire)
  );

  // ==========================================================================
  // Window comparison. A divided edge in the same cycle as the reference
  // edge counts as inside the window.
  always_comb begin
    cmp_d = cmp_q;
    hit   = 1'b0;
    miss  = 1'b0;
    unique case (cmp_q)
      CMP_IDLE: begin
        if (win_start && div_rise) begin
          hit   = 1'b1;
          cmp_d = CMP_HIT;
        end else if (win_start) begin
          cmp_d = CMP_OPEN;
        end else if (div_rise) begin
          miss  = 1'b1;
        end
      end
      CMP_OPEN: begin
        if (div_rise && (win_open || win_start)) begin
          hit   = 1'b1;
          cmp_d = CMP_HIT;
        end else if (win_start || win_expire) begin
          miss  = 1'b1;
          cmp_d = win_start ? CMP_OPEN : CMP_IDLE;
        end
      end
      CMP_HIT: begin
        if (win_start && div_rise) begin
          hit   = 1'b1;
        end else if (win_start) begin
          cmp_d = CMP_OPEN;
        end else if (div_rise) begin
          miss  = 1'b1;
          cmp_d = CMP_IDLE;
        end else if (!win_open) begin
          cmp_d = CMP_IDLE;
        end
      end
      default: begin
        cmp_d = CMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !cfg_q.enable) begin
      cmp_q <= CMP_IDLE;
    end else begin
      cmp_q <= cmp_d;
    end
  end

  // ==========================================================================
  // Consecutive tally and lock flag.
  assign target = lock_target(cfg_q.count_code);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !cfg_q.enable) begin
      tally_q <= '0;
    end else if (miss) begin
      tally_q <= '0;
    end else if (hit && (tally_q < target)) begin
      tally_q <= tally_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !cfg_q.enable) begin
      lock_q <= 1'b0;
    end else if (miss) begin
      lock_q <= 1'b0;
    end else if (hit && (tally_q + 1'b1 >= target)) begin
      lock_q <= 1'b1;
    end else if (tally_q >= target) begin
      lock_q <= 1'b1;
    end else begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
    end
  end

  assign lock_gained   = lock_q && !lock_prev_q;
  assign lock_lost     = !lock_q && lock_prev_q;
  assign lock_flag_out = lock_q;

  // ==========================================================================
  // Single automatic relock try. The try is re-armed only once lock is
  // regained, so a failed try is not repeated.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      relock_armed_q <= 1'b1;
    end else if (lock_gained) begin
      relock_armed_q <= 1'b1;
    end else if (lock_lost && cfg_q.relock) begin
      relock_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      relock_req_q <= 1'b0;
    end else begin
      relock_req_q <= lock_lost && cfg_q.relock && relock_armed_q;
    end
  end

  assign relock_req_out = relock_req_q;

  // ==========================================================================
  // Avalon-MM slave. Every access waits one cycle, then completes.
  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !ack_q;
  assign wr_take             = avs_write_in && ack_q;
  assign rd_take             = avs_read_in && ack_q;
  assign idx                 = word_index(avs_address_in);
  assign status_rd           = rd_take && (idx == STATUS_INDEX);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  // Byte-lane merge of write data into the 24-bit configuration word.
  assign cfg_bits = cfg_q;
  always_comb begin
    cfg_merge = cfg_bits;
    for (int b = 0; b < 3; b++) begin
      if (avs_byteenable_in[b]) begin
        cfg_merge[b*8 +: 8] = avs_writedata_in[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_q <= CFG_RESET;
    end else if (wr_take && (idx == CFG_INDEX)) begin
      cfg_q <= cfg_merge;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_q <= MASK_RESET;
    end else if (wr_take && (idx == MASK_INDEX) && avs_byteenable_in[0]) begin
      mask_q <= avs_writedata_in[STATUS_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // Sticky event status; a new event beats the clear of a status read.
  assign events.gained = lock_gained;
  assign events.lost   = lock_lost;
  assign events.relock = relock_req_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_q <= '0;
    end else if (status_rd) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end

  assign irq_out = |(status_q & mask_q);

  // ==========================================================================
  // Read data, registered so it stands at the completing edge.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      unique case (idx)
        CFG_INDEX:    readdata_q <= {8'h00, cfg_bits};
        STATUS_INDEX: readdata_q <= {29'h0000_0000, status_q | events};
        MASK_INDEX:   readdata_q <= {29'h0000_0000, mask_q};
        STATE_INDEX:  readdata_q <= {12'h000, cmp_q, lock_q, tally_q};
        default:      readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_out = readdata_q;

endmodule // lock_detector
`default_nettype wire

// >>> tb/lock_detector_properties.sv
// Port-level assertions for the lock detector.
`timescale 1ns/1ps
`default_nettype none
module lock_detector_properties (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        ref_edge_in,
  input wire logic        div_edge_in,
  input wire logic        lock_flag_out,
  input wire logic        relock_req_out,
  input wire logic        irq_out
);
  localparam int TGT [8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
  logic [23:0] cfg_q;
  logic [16:0] refs_q;
  logic        seen_q, armed_q, lock_q, ref_q;
  logic        done, short_win;
  assign done = avs_read_in && !avs_waitrequest_out;
  assign short_win = !cfg_q[6] || (cfg_q[9:7] <= 3'h2 && cfg_q[11:10] == 2'h0);
  // ==========
  // Shadow of the configuration and of the lock history.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_q  <= 24'h00014D;
      seen_q <= 1'b0;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h1C) begin
      for (int i = 0; i < 3; i++)
        if (avs_byteenable_in[i]) cfg_q[8*i +: 8] <= avs_writedata_in[8*i +: 8];
      seen_q <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    lock_q <= lock_flag_out;
    ref_q  <= ref_edge_in;
    if (rst_in || !cfg_q[3] || (lock_q && !lock_flag_out)) refs_q <= '0;
    else refs_q <= refs_q + 17'(ref_edge_in && !ref_q);
    if (rst_in || relock_req_out) armed_q <= 1'b0;
    else if (lock_flag_out && !lock_q) armed_q <= 1'b1;
  end
  // ==========
  // Properties.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_bus_one_wait:
    assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read did not take one wait cycle");
  a_cfg_reset:
    assert property (done && avs_address_in == 8'h1C && !seen_q |-> avs_readdata_out == 32'h14D)
    else $error("config reset value wrong");
  a_unmapped_zero:
    assert property (done && !(avs_address_in[7:2] inside {6'h07, 6'h08, 6'h09, 6'h0A})
      |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  a_disabled_dark:
    assert property (!cfg_q[3] [*3] |-> !lock_flag_out) else $error("lock while disabled");
  a_lock_count:
    assert property ($rose(lock_flag_out) |-> int'(refs_q) + 1 >= TGT[cfg_q[2:0]])
    else $error("lock before the selected count");
  a_miss_drops:
    assert property (cfg_q[3] && short_win && $rose(ref_edge_in) && !div_edge_in
      ##1 !div_edge_in [*8] |-> ##[0:16] !lock_flag_out) else $error("lock kept after miss");
  a_relock_after:
    assert property ($fell(lock_flag_out) && cfg_q[13] && armed_q |-> ##[1:2] relock_req_out)
    else $error("no relock attempt");
  a_relock_once:
    assert property (relock_req_out |-> armed_q && cfg_q[13] && !lock_flag_out)
    else $error("relock attempt not armed");
endmodule // lock_detector_properties
bind lock_detector lock_detector_properties i_props (.*);
`default_nettype wire

// >>> tb/pd_feedback_model.sv
// Reference and divided-oscillator pulse source facing the lock detector.
`timescale 1ns/1ps
`default_nettype none
module pd_feedback_model (
  input  wire logic       sys_clk_in,
  input  wire logic       en_in,
  input  wire logic       skip_in,
  input  wire logic [3:0] delay_in,
  output logic            ref_out,
  output logic            div_out,
  output logic [16:0]     pulses_out
);
  logic [4:0] t_q;
  // Each 24-cycle period carries one reference pulse and, unless skipped, a delayed divider pulse.
  always_ff @(posedge sys_clk_in) begin
    t_q        <= (!en_in || t_q == 5'h17) ? 5'h0 : t_q + 5'h1;
    pulses_out <= !en_in ? 17'h0 : pulses_out + 17'(t_q == 5'h0);
  end
  assign ref_out = en_in && t_q < 5'h4;
  assign div_out = en_in && !skip_in && t_q >= 5'(delay_in) && t_q < 5'(delay_in) + 5'h4;
endmodule // pd_feedback_model
`default_nettype wire

// >>> tb/lock_detector_tb.sv
// Self-checking bench for the lock detector.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lock_detector_tb;
  import lock_detect_pkg::*;
  logic        sys_clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic [7:0]  avs_address_in = 0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 0, pm = 0, r, act, exp_v;
  logic        take = 0, p_en = 0, p_skip = 0;
  logic [3:0]  p_dly = 0;
  logic [31:0] q [$];
  logic [11:0] w;
  logic [11:0] win [10] = '{12'hD14, 12'hF95, 12'hD75, 12'hB94, 12'hB81, 12'hC01, 12'h500,
                            12'hFF5, 12'hDAF, 12'hDB2};
  wire logic [31:0] avs_readdata_out;
  wire logic        avs_waitrequest_out, ref_edge_in, div_edge_in;
  wire logic        lock_flag_out, relock_req_out, irq_out;
  wire logic [16:0] pulses;
  int miscompares = 0, samples_checked = 0, cycles = 0, relocks = 0, seed = 77;
  int tg [5] = '{5, 32, 96, 256, 512};
  lock_cfg_type c;
  lock_detector i_dut (.*);
  pd_feedback_model i_far (.sys_clk_in(sys_clk_in), .en_in(p_en), .skip_in(p_skip),
    .delay_in(p_dly), .ref_out(ref_edge_in), .div_out(div_edge_in), .pulses_out(pulses));
  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  // ==========
  // Result watcher: takes the oldest expected note whenever a read or probe completes.
  always @(posedge sys_clk_in) begin
    if (relock_req_out === 1'b1) relocks++;
    if ((avs_read_in && avs_waitrequest_out === 1'b0) || take) begin
      exp_v = q.pop_front();
      act = take ? ({pulses, 7'h0, lock_flag_out, irq_out, 6'(relocks)} & pm) : avs_readdata_out;
      `CHK(act, exp_v)
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_read_in      <= !wr;
    avs_write_in     <= wr;
    avs_address_in   <= a;
    avs_writedata_in <= d;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in  <= 0;
    avs_write_in <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 0);
  endtask
  task automatic probe(input logic [31:0] m, input logic [31:0] e);
    q.push_back(e);
    @(posedge sys_clk_in);
    pm   <= m;
    take <= 1;
    @(posedge sys_clk_in);
    take <= 0;
  endtask
  task automatic cfg(input logic [2:0] k, input logic en, input logic wt,
                     input logic [2:0] dur, input logic [1:0] rate, input logic rl);
    c = '0;
    c.count_code = k;
    c.enable = en;
    c.wtype = wt;
    c.duration = dur;
    c.rate = rate;
    c.relock = rl;
    bus(1, 8'h1C, {8'h00, c});
  endtask
  task automatic await(input logic v, input int n);
    for (int i = 0; i < n && lock_flag_out !== v; i++) @(posedge sys_clk_in);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 0;
    rd(8'h1C, 32'h14D);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    r = $random(seed);
    bus(1, 8'h40, r);
    rd(8'h40, 32'h0);
    bus(1, 8'h1C, r);
    rd(8'h1C, r & 32'h00FFFFFF);
    $display("registers done");
    cfg(0, 1, 1, 2, 0, 1);
    bus(1, 8'h24, 32'h7);
    p_en <= 1;
    await(1, 400);
    rd(8'h20, 32'h1);
    p_skip <= 1;
    await(0, 100);
    repeat (40) @(posedge sys_clk_in);
    probe(32'hFF, 32'h41);
    rd(8'h20, 32'h6);
    probe(32'hFF, 32'h01);
    bus(1, 8'h24, 32'h0);
    p_skip <= 0;
    await(1, 400);
    probe(32'hFF, 32'h81);
    bus(1, 8'h24, 32'h1);
    probe(32'hFF, 32'hC1);
    rd(8'h20, 32'h1);
    probe(32'hFF, 32'h81);
    $display("relock and interrupt done");
    for (int k = 0; k < 5; k++) begin
      p_en <= 0;
      cfg(3'(k), 0, 1, 2, 0, 0);
      cfg(3'(k), 1, 1, 2, 0, 0);
      p_en <= 1;
      await(1, tg[k] * 24 + 100);
      probe(32'hFFFF8080, {17'(tg[k]), 15'h80});
      rd(8'h28, 32'h20000 | tg[k]);
    end
    $display("lock counts done");
    foreach (win[j]) begin
      w = win[j];
      p_en <= 0;
      cfg(0, 0, 1, 2, 0, 0);
      rd(8'h28, 32'h0);
      p_dly <= w[4:1];
      cfg(0, w[11], w[10], w[9:7], w[6:5], 0);
      p_en <= 1;
      repeat (200) @(posedge sys_clk_in);
      probe(32'h80, {24'h0, w[0], 7'h0});
    end
    $display("windows done");
    conclude();
  end
endmodule // lock_detector_tb
`default_nettype wire
